// File: verilog/atw_defs.svh
// Purpose: constants for the asynchronous timer waveform unit
// Assumes: byte addressed apb, one 32-bit word per register
// Notes: offsets other than control a sit on the following words
//
// How it works
// - tick source is system clock unless async select
// - async select releases both oscillator pins
// - prescaler gives 1,8,32,64,128,256,1024 or stop
// - prescaler reset bit clears prescaler phase
// - nonzero output mode overrides pin port function
// - non-pwm: disconnect, toggle, clear, set on match
// - fast pwm a: toggle if top select, clear/set
// - fast pwm b: 01 reserved, clear/set at bottom
// - phase pwm a: direction dependent clear/set, toggle
// - phase pwm b: 01 reserved, direction dependent
// - compare equal top: act at top instead
// - control a bits 3:2 read zero
// - waveform mode codes select operating mode
// - top is max or compare a by mode
// - compare update and overflow point by mode
// - clock select codes map stop through 1024
// - async writes land after two oscillator edges
`ifndef ATW_DEFS_SVH
`define ATW_DEFS_SVH
// ====================================================
// register offsets
`define ATW_OFS_CTRL_A 8'hb0
`define ATW_OFS_CTRL_B 8'hb4
`define ATW_OFS_COUNT 8'hb8
`define ATW_OFS_CMP_A 8'hbc
`define ATW_OFS_CMP_B 8'hc0
`define ATW_OFS_ASYNC 8'hc4
`define ATW_OFS_GTC 8'hc8
`define ATW_OFS_ISR 8'hcc
`define ATW_OFS_IMR 8'hd0
// ====================================================
// fields and reset values
`define ATW_CTRL_A_WMASK 8'hf3
`define ATW_CB_FOC_A 7
`define ATW_CB_FOC_B 6
`define ATW_ASYNC_SEL_BIT 5
`define ATW_PSR_BIT 1
`define ATW_REG_RESET 8'h00
`define ATW_MAX 8'hff
`define ATW_BOTTOM 8'h00
// temp register index, also async status bit position
`define ATW_IDX_CTRL_B 0
`define ATW_IDX_CTRL_A 1
`define ATW_IDX_CMP_B 2
`define ATW_IDX_CMP_A 3
`define ATW_IDX_COUNT 4
// ====================================================
// timing
`define ATW_OSC_SETTLE_EDGES 2'h2
`endif

// File: verilog/atw_pkg.sv
// Purpose: types for the asynchronous timer waveform unit
// Assumes: nothing
// Notes: reserved waveform codes fall back to plain counting
package atw_pkg;
   typedef enum logic [2:0] {
      mode_normal,
      mode_phase,
      mode_clear_on_match,
      mode_fast,
      mode_rsvd
   } atw_mode_type;
endpackage

// File: verilog/atw_timer.sv
// Purpose: 8-bit timer with two compare waveform outputs behind apb
// Assumes: oscillator pin is sampled as a synchronous input
// Notes: one clock domain, oscillator edges become enables
`timescale 1ns/1ps
`include "atw_defs.svh"
module atw_timer (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // oscillator pin
   input wire logic i_osc_in_pin,
   output logic o_osc_pins_released,
   // waveform pins
   output logic o_wave_out_a,
   output logic o_wave_out_b,
   output logic o_wave_a_override,
   output logic o_wave_b_override,
   // interrupt
   output logic o_irq
);
   // ====================================================
   // apb handshake
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   wire req_phase = i_psel & i_penable & ~pready_q;
   wire acc_done = i_psel & i_penable & pready_q;
   wire wr_en = acc_done & i_pwrite;
   wire hit_ctrl_a = (i_paddr == `ATW_OFS_CTRL_A);
   wire hit_ctrl_b = (i_paddr == `ATW_OFS_CTRL_B);
   wire hit_count = (i_paddr == `ATW_OFS_COUNT);
   wire hit_cmp_a = (i_paddr == `ATW_OFS_CMP_A);
   wire hit_cmp_b = (i_paddr == `ATW_OFS_CMP_B);
   wire hit_async = (i_paddr == `ATW_OFS_ASYNC);
   wire hit_gtc = (i_paddr == `ATW_OFS_GTC);
   wire hit_isr = (i_paddr == `ATW_OFS_ISR);
   wire hit_imr = (i_paddr == `ATW_OFS_IMR);
   wire hit_any = hit_ctrl_a | hit_ctrl_b | hit_count | hit_cmp_a | hit_cmp_b |
      hit_async | hit_gtc | hit_isr | hit_imr;
   // ====================================================
   // state
   logic [7:0] ctrl_a_q;
   logic [3:0] ctrl_b_q;
   logic [7:0] cnt_q;
   logic [7:0] cmp_a_buf_q;
   logic [7:0] cmp_b_buf_q;
   logic [7:0] cmp_a_q;
   logic [7:0] cmp_b_q;
   logic async_q;
   logic [9:0] pre_q;
   logic dir_up_q;
   logic block_q;
   logic [2:0] isr_q;
   logic [2:0] imr_q;
   logic irq_q;
   logic osc_s1_q;
   logic osc_s2_q;
   logic osc_s3_q;
   logic ovr_a_q;
   logic ovr_b_q;
   logic rel_q;
   wire [4:0] wr_hit = {hit_count, hit_cmp_a, hit_cmp_b, hit_ctrl_a, hit_ctrl_b} &
      {5{wr_en}};
   wire [4:0] commit_w;
   wire [4:0] busy_w;
   wire [7:0] commit_val_w [5];
   // ====================================================
   // oscillator edge
   // one extra stage keeps the edge detector off the first flop
   wire osc_rise = osc_s2_q & ~osc_s3_q;
   wire src_tick = async_q ? osc_rise : 1'b1;
   // ====================================================
   // mode decode
   wire [2:0] cs = ctrl_b_q[2:0];
   wire top_sel = ctrl_b_q[3];
   wire [2:0] wgm = {top_sel, ctrl_a_q[1:0]};
   atw_pkg::atw_mode_type mode;
   assign mode = (wgm == 3'h0) ? atw_pkg::mode_normal :
      (wgm == 3'h1 || wgm == 3'h5) ? atw_pkg::mode_phase :
      (wgm == 3'h2) ? atw_pkg::mode_clear_on_match :
      (wgm == 3'h3 || wgm == 3'h7) ? atw_pkg::mode_fast : atw_pkg::mode_rsvd;
   wire is_phase = (mode == atw_pkg::mode_phase);
   wire is_fast = (mode == atw_pkg::mode_fast);
   wire non_pwm = ~is_phase & ~is_fast;
   wire [7:0] top = (wgm == 3'h2 || wgm == 3'h5 || wgm == 3'h7) ? cmp_a_q : `ATW_MAX;
   wire at_top = (cnt_q == top);
   wire at_bottom = (cnt_q == `ATW_BOTTOM);
   // ====================================================
   // prescaler taps
   // clock select mapping
   wire tap_sel = (cs == 3'h1) ? 1'b1 :
      (cs == 3'h2) ? &pre_q[2:0] :
      (cs == 3'h3) ? &pre_q[4:0] :
      (cs == 3'h4) ? &pre_q[5:0] :
      (cs == 3'h5) ? &pre_q[6:0] :
      (cs == 3'h6) ? &pre_q[7:0] :
      (cs == 3'h7) ? &pre_q[9:0] : 1'b0;
   wire tick = src_tick & tap_sel;
   wire psr_wr = wr_en & hit_gtc & i_pwdata[`ATW_PSR_BIT];
   // ====================================================
   // temporary registers for the oscillator domain
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_tmp
         logic [7:0] tmp_q;
         logic pend_q;
         logic [1:0] edge_q;
         wire last_edge = pend_q & osc_rise & (edge_q == `ATW_OSC_SETTLE_EDGES - 2'h1);
         // hold then land after two edges
         always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
               tmp_q <= 8'h00;
               pend_q <= 1'b0;
               edge_q <= 2'h0;
            end else if (wr_hit[gi] && async_q) begin
               tmp_q <= i_pwdata[7:0];
               pend_q <= 1'b1;
               edge_q <= 2'h0;
            end else if (last_edge) begin
               pend_q <= 1'b0;
            end else if (pend_q && osc_rise) begin
               edge_q <= edge_q + 2'h1;
            end
         end
         assign commit_w[gi] = (wr_hit[gi] & ~async_q) | last_edge;
         assign commit_val_w[gi] = last_edge ? tmp_q : i_pwdata[7:0];
         assign busy_w[gi] = pend_q;
      end
   endgenerate
   // ====================================================
   // apb bus flops
   wire [7:0] rd_byte = hit_ctrl_a ? ctrl_a_q :
      hit_ctrl_b ? {4'h0, ctrl_b_q} :
      hit_count ? cnt_q :
      hit_cmp_a ? cmp_a_buf_q :
      hit_cmp_b ? cmp_b_buf_q :
      hit_async ? {2'b00, async_q, busy_w} :
      hit_isr ? {5'h00, isr_q} :
      hit_imr ? {5'h00, imr_q} : 8'h00;
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= req_phase;
         if (req_phase) begin
            pslverr_q <= ~hit_any;
            prdata_q <= {24'h00_0000, rd_byte};
         end
      end
   end
   // ====================================================
   // control registers
   wire force_a = commit_w[`ATW_IDX_CTRL_B] & commit_val_w[`ATW_IDX_CTRL_B][`ATW_CB_FOC_A] &
      non_pwm;
   wire force_b = commit_w[`ATW_IDX_CTRL_B] & commit_val_w[`ATW_IDX_CTRL_B][`ATW_CB_FOC_B] &
      non_pwm;
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_a_q <= `ATW_REG_RESET;
         ctrl_b_q <= 4'h0;
         async_q <= 1'b0;
         imr_q <= 3'h0;
      end else begin
         if (commit_w[`ATW_IDX_CTRL_A])
            ctrl_a_q <= commit_val_w[`ATW_IDX_CTRL_A] & `ATW_CTRL_A_WMASK;
         if (commit_w[`ATW_IDX_CTRL_B])
            ctrl_b_q <= commit_val_w[`ATW_IDX_CTRL_B][3:0];
         if (wr_en && hit_async)
            async_q <= i_pwdata[`ATW_ASYNC_SEL_BIT];
         if (wr_en && hit_imr)
            imr_q <= i_pwdata[2:0];
      end
   end
   // ====================================================
   // compare buffers
   // update point by mode; non-pwm lags one clock
   wire cmp_upd = non_pwm | (tick & at_top);
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cmp_a_buf_q <= 8'h00;
         cmp_b_buf_q <= 8'h00;
         cmp_a_q <= 8'h00;
         cmp_b_q <= 8'h00;
      end else begin
         if (commit_w[`ATW_IDX_CMP_A])
            cmp_a_buf_q <= commit_val_w[`ATW_IDX_CMP_A];
         if (commit_w[`ATW_IDX_CMP_B])
            cmp_b_buf_q <= commit_val_w[`ATW_IDX_CMP_B];
         if (cmp_upd) begin
            cmp_a_q <= cmp_a_buf_q;
            cmp_b_q <= cmp_b_buf_q;
         end
      end
   end
   // ====================================================
   // prescaler and counter
   // eight bit count wraps from top to bottom, or turns at top and bottom in phase mode
   wire [7:0] cnt_inc = cnt_q + 8'h01;
   wire [7:0] cnt_dec = cnt_q - 8'h01;
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pre_q <= 10'h000;
      end else if (psr_wr) begin
         pre_q <= 10'h000;
      end else if (src_tick) begin
         pre_q <= pre_q + 10'h001;
      end
   end
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= `ATW_BOTTOM;
         dir_up_q <= 1'b1;
         block_q <= 1'b0;
      end else if (commit_w[`ATW_IDX_COUNT]) begin
         cnt_q <= commit_val_w[`ATW_IDX_COUNT];
         block_q <= 1'b1;
      end else if (tick) begin
         block_q <= 1'b0;
         if (!is_phase) begin
            cnt_q <= at_top ? `ATW_BOTTOM : cnt_inc;
         end else if (dir_up_q) begin
            dir_up_q <= ~at_top;
            cnt_q <= at_top ? (at_bottom ? `ATW_BOTTOM : cnt_dec) : cnt_inc;
         end else begin
            dir_up_q <= at_bottom;
            cnt_q <= at_bottom ? cnt_inc : cnt_dec;
         end
      end
   end
   // ====================================================
   // events and interrupt
   // overflow point by mode
   wire ovf_ev = tick & (is_phase ? (at_bottom & ~dir_up_q) :
      (wgm == 3'h7) ? at_top : (cnt_q == `ATW_MAX));
   wire match_a = tick & ~block_q & (cnt_q == cmp_a_q);
   wire match_b = tick & ~block_q & (cnt_q == cmp_b_q);
   wire [2:0] isr_clr = (wr_en && hit_isr) ? i_pwdata[2:0] : 3'h0;
   // set wins over a clear in the same cycle
   wire [2:0] isr_d = (isr_q & ~isr_clr) | {match_b, match_a, ovf_ev};
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         isr_q <= 3'h0;
         irq_q <= 1'b0;
      end else begin
         isr_q <= isr_d;
         irq_q <= |(isr_q & imr_q);
      end
   end
   // ====================================================
   // waveform channels
   wire [1:0] com_w [2];
   wire [7:0] ocr_w [2];
   wire [1:0] match_w = {match_b, match_a};
   wire [1:0] force_w = {force_b, force_a};
   wire [1:0] wave_w;
   assign com_w[0] = ctrl_a_q[7:6];
   assign com_w[1] = ctrl_a_q[5:4];
   assign ocr_w[0] = cmp_a_q;
   assign ocr_w[1] = cmp_b_q;
   wire bottom_ev = tick & at_bottom;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_wave
         logic wave_q;
         logic wave_d;
         // only channel a may toggle in pwm, and only with top select
         wire tog_ok = (gi == 0) & top_sel;
         // compare at top acts as up-count event
         wire spec = com_w[gi][1] & (ocr_w[gi] == top);
         wire up = dir_up_q | spec;
         always_comb begin
            wave_d = wave_q;
            if (non_pwm) begin
               if (match_w[gi] || force_w[gi]) begin
                  case (com_w[gi])
                     2'b01: wave_d = ~wave_q;
                     2'b10: wave_d = 1'b0;
                     2'b11: wave_d = 1'b1;
                     default: wave_d = wave_q;
                  endcase
               end
            end else if (is_fast) begin
               if (match_w[gi]) begin
                  case (com_w[gi])
                     2'b01: wave_d = tog_ok ? ~wave_q : wave_q;
                     2'b10: wave_d = 1'b0;
                     2'b11: wave_d = 1'b1;
                     default: wave_d = wave_q;
                  endcase
               end else if (bottom_ev && com_w[gi][1]) begin
                  wave_d = ~com_w[gi][0];
               end
            end else begin
               if (match_w[gi]) begin
                  case (com_w[gi])
                     2'b01: wave_d = tog_ok ? ~wave_q : wave_q;
                     2'b10: wave_d = ~up;
                     2'b11: wave_d = up;
                     default: wave_d = wave_q;
                  endcase
               end
            end
         end
         always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
               wave_q <= 1'b0;
            end else begin
               wave_q <= wave_d;
            end
         end
         assign wave_w[gi] = wave_q;
      end
   endgenerate
   // ====================================================
   // pin control flops
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
         ovr_a_q <= 1'b0;
         ovr_b_q <= 1'b0;
         rel_q <= 1'b0;
      end else begin
         osc_s1_q <= i_osc_in_pin;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
         ovr_a_q <= |ctrl_a_q[7:6];
         ovr_b_q <= |ctrl_a_q[5:4];
         rel_q <= async_q;
      end
   end
   // ====================================================
   // outputs
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_wave_out_a = wave_w[0];
   assign o_wave_out_b = wave_w[1];
   assign o_wave_a_override = ovr_a_q;
   assign o_wave_b_override = ovr_b_q;
   assign o_osc_pins_released = rel_q;
   assign o_irq = irq_q;
   // ====================================================
   // assertions
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);
   sequence s_async_cmp_wr;
      async_q && wr_hit[`ATW_IDX_CMP_A];
   endsequence
   sequence s_held_then_busy;
      busy_w[`ATW_IDX_CMP_A] && $stable(cmp_a_buf_q);
   endsequence
   AST_RSVD_ZERO: assert property (ctrl_a_q[3:2] == 2'b00)
      else $error("reserved control bits not zero");
   AST_STOP_HOLDS: assert property ((cs == 3'h0 && !commit_w[`ATW_IDX_COUNT])
      |=> $stable(cnt_q)) else $error("counter moved while stopped");
   AST_SYNC_SOURCE: assert property ((!async_q && cs == 3'h1 && wgm == 3'h0 &&
      !commit_w[`ATW_IDX_COUNT]) |=> cnt_q == 8'($past(cnt_q) + 8'h01))
      else $error("undivided sync count did not advance");
   AST_ASYNC_SOURCE: assert property ((async_q && !osc_rise &&
      !commit_w[`ATW_IDX_COUNT]) |=> $stable(cnt_q)) else $error("async count without edge");
   AST_PRESCALE_CLR: assert property (psr_wr |=> pre_q == 10'h000)
      else $error("prescaler not cleared");
   // async write parked in temp register
   AST_ASYNC_HOLD: assert property (s_async_cmp_wr |=> s_held_then_busy)
      else $error("async compare write not held");
   AST_CLEAR_MATCH: assert property ((non_pwm && com_w[0] == 2'b10 && match_a)
      |=> !o_wave_out_a) else $error("wave a not cleared on match");
   // clear on match wraps at compare a
   AST_MATCH_CLEAR_WRAP: assert property ((wgm == 3'h2 && tick && cnt_q == cmp_a_q &&
      !commit_w[`ATW_IDX_COUNT]) |=> cnt_q == `ATW_BOTTOM)
      else $error("clear on match count did not wrap");
   // fast pwm inverting clears at bottom
   AST_FAST_BOTTOM: assert property ((is_fast && com_w[1] == 2'b11 && bottom_ev &&
      !match_b) |=> !o_wave_out_b) else $error("wave b not cleared at bottom");
   // overflow at max in normal mode
   AST_OVF_MAX: assert property ((wgm == 3'h0 && tick && cnt_q == `ATW_MAX)
      |=> isr_q[0]) else $error("overflow flag missing");
   AST_IRQ_LEVEL: assert property ((|(isr_q & imr_q)) |=> o_irq)
      else $error("interrupt not raised");
endmodule // atw_timer

// File: sim/atw_pin_model.sv
// Purpose: port pins and watch crystal at the far side of the timer
// Assumes: each pin has a pull-up while the timer leaves it alone
// Notes: the crystal runs free, as a real one does
`timescale 1ns/1ps
module atw_pin_model #(
   parameter int HALF_NS = 100
) (
   // crystal
   output logic o_osc,
   // waveform side
   input wire logic i_wave_a,
   input wire logic i_wave_b,
   input wire logic i_over_a,
   input wire logic i_over_b,
   // pin levels
   output logic o_pin_a,
   output logic o_pin_b
);
   // ==========================================
   // crystal
   // free running crystal
   // odd start offset keeps its edges off the system clock edges
   initial begin
      o_osc = 1'b0;
      #7;
      forever begin
         #HALF_NS;
         o_osc = ~o_osc;
      end
   end
   // ==========================================
   // pins
   // waveform takes the pin only while overriding
   assign o_pin_a = i_over_a ? i_wave_a : 1'b1;
   assign o_pin_b = i_over_b ? i_wave_b : 1'b1;
endmodule // atw_pin_model

// File: sim/test_async_timer_waveform_unit.sv
// Purpose: self-checking bench for the asynchronous timer waveform unit
// Assumes: crystal model on the oscillator pin, pins read through pull-ups
// Notes: pwm shape is judged from edge counts over whole periods
`timescale 1ns/1ps
`include "atw_defs.svh"
module test_async_timer_waveform_unit;
   // ==========================================
   // signals
   logic i_clock = 1'b0;
   logic i_rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, osc, released, wave_a, wave_b, over_a, over_b, irq, pin_a, pin_b, e;
   int bad_count = 0;
   int checks = 0;
   int ta, tb, ha;
   int div [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   logic [7:0] rst_addr [8] = '{8'hb0, 8'hb4, 8'hb8, 8'hbc, 8'hc0, 8'hc4, 8'hcc, 8'hd0};
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} atw_row_type;
   atw_row_type rows [8] = '{'{8'hb0, 8'hff, 8'hf3, 1'b0}, '{8'hb0, 8'h00, 8'h00, 1'b0},
      '{8'hbc, 8'h5a, 8'h5a, 1'b0}, '{8'hc0, 8'ha5, 8'ha5, 1'b0}, '{8'hc8, 8'h02, 8'h00, 1'b0},
      '{8'hd4, 8'h77, 8'h00, 1'b1}, '{8'hd0, 8'h07, 8'h07, 1'b0}, '{8'hd0, 8'h00, 8'h00, 1'b0}};
   always #12.5 i_clock = ~i_clock;
   atw_timer atw_timer_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_osc_in_pin(osc),
      .o_osc_pins_released(released), .o_wave_out_a(wave_a), .o_wave_out_b(wave_b),
      .o_wave_a_override(over_a), .o_wave_b_override(over_b), .o_irq(irq));
   atw_pin_model atw_pin_model_i (.o_osc(osc), .i_wave_a(wave_a), .i_wave_b(wave_b),
      .i_over_a(over_a), .i_over_b(over_b), .o_pin_a(pin_a), .o_pin_b(pin_b));
   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // no cycle count assumed: wait for pready, bounded by a limit
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic er);
      int n = 0;
      @(posedge i_clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      do begin
         @(posedge i_clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      q = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] q);
      apb(1'b0, a, 32'h0, r, e);
      chk(r, {24'h0, q});
   endtask
   // no rewrite until the transfer has landed
   task automatic wait_idle;
      apb(1'b0, `ATW_OFS_ASYNC, 32'h0, r, e);
      repeat (40) if (r[4:0] !== 5'h00) apb(1'b0, `ATW_OFS_ASYNC, 32'h0, r, e);
      chk(r[4:0], 0);
   endtask
   task automatic cfg(input logic [7:0] ca, input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] cb);
      wr(`ATW_OFS_CTRL_B, 8'h00);
      wr(`ATW_OFS_CTRL_A, 8'h00);
      wr(`ATW_OFS_CMP_A, a);
      wr(`ATW_OFS_CMP_B, b);
      wr(`ATW_OFS_COUNT, 8'h00);
      wr(`ATW_OFS_CTRL_A, ca);
      wr(`ATW_OFS_CTRL_B, cb);
   endtask
   // edges on both pins and high time on pin a, sampled mid-cycle
   task automatic meas(input int n);
      logic pa, pb;
      ta = 0; tb = 0; ha = 0;
      @(negedge i_clock);
      pa = pin_a; pb = pin_b;
      repeat (n) begin
         @(negedge i_clock);
         ta += (pin_a !== pa); tb += (pin_b !== pb); ha += (pin_a === 1'b1);
         pa = pin_a; pb = pin_b;
      end
   endtask
   task automatic test_done;
      if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================
   // watchdog
   initial begin
      repeat (40000) @(posedge i_clock);
      bad_count++;
      test_done;
   end
   // ==========================================
   // sequence
   initial begin
      repeat (6) @(posedge i_clock);
      i_rst_b <= 1'b1;
      chk({released, over_a, over_b, irq}, 0);
      foreach (rst_addr[i]) rd_chk(rst_addr[i], 8'h00);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, {24'h0, rows[i].d}, r, e);
         chk(e, rows[i].e);
         rd_chk(rows[i].a, rows[i].q);
      end
      // clear on match with top 1: one toggle per two ticks
      for (int cs = 0; cs < 8; cs++) begin
         cfg(8'h42, 8'h01, 8'h01, 8'(cs));
         repeat (8 * div[cs] + 4) @(posedge i_clock);
         meas(cs == 0 ? 64 : 8 * div[cs]);
         chk(ta, cs == 0 ? 0 : 4);
      end
      for (int k = 0; k < 2; k++) begin
         cfg(k ? 8'hf2 : 8'ha2, 8'h01, 8'h01, 8'h01);
         repeat (16) @(negedge i_clock);
         chk(pin_b, k);
         chk(pin_a, k);
      end
      cfg(8'h02, 8'h01, 8'h01, 8'h01);
      repeat (16) @(negedge i_clock);
      chk({over_a, pin_a}, 2'h1);
      cfg(8'hb3, 8'h3f, 8'h3f, 8'h01);
      repeat (300) @(posedge i_clock);
      meas(256);
      chk(ta, 2);
      chk(tb, 2);
      chk(ha inside {[63:64]}, 1);
      for (int k = 0; k < 2; k++) begin
         cfg(8'h43, 8'h0f, 8'h00, k ? 8'h09 : 8'h01);
         repeat (64) @(posedge i_clock);
         meas(128);
         chk(ta, k ? 8 : 0);
      end
      cfg(8'hb1, 8'h40, 8'h40, 8'h01);
      repeat (600) @(posedge i_clock);
      meas(510);
      chk(ta, 2);
      chk(tb, 2);
      chk(pin_a ^ pin_b, 1);
      cfg(8'h00, 8'h80, 8'h80, 8'h01);
      wr(`ATW_OFS_ISR, 8'h07);
      wr(`ATW_OFS_IMR, 8'h00);
      repeat (300) @(posedge i_clock);
      rd_chk(`ATW_OFS_ISR, 8'h07);
      chk(irq, 0);
      wr(`ATW_OFS_IMR, 8'h01);
      repeat (2) @(negedge i_clock);
      chk(irq, 1);
      wr(`ATW_OFS_CTRL_B, 8'h00);
      wr(`ATW_OFS_ISR, 8'h07);
      repeat (2) @(negedge i_clock);
      chk(irq, 0);
      rd_chk(`ATW_OFS_ISR, 8'h00);
      // async: writes go through the holding registers
      wr(`ATW_OFS_ASYNC, 8'h20);
      repeat (2) @(negedge i_clock);
      chk(released, 1);
      wr(`ATW_OFS_CMP_A, 8'h33);
      apb(1'b0, `ATW_OFS_ASYNC, 32'h0, r, e);
      chk(r[3], 1);
      wait_idle;
      rd_chk(`ATW_OFS_CMP_A, 8'h33);
      wr(`ATW_OFS_CMP_A, 8'h01);
      wait_idle;
      wr(`ATW_OFS_CTRL_A, 8'h42);
      wait_idle;
      // counter left mid-range by the stopped run; restart it below top
      wr(`ATW_OFS_COUNT, 8'h00);
      wait_idle;
      wr(`ATW_OFS_CTRL_B, 8'h01);
      wait_idle;
      repeat (32) @(posedge i_clock);
      meas(128);
      chk(ta, 8);
      @(posedge i_clock);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd_chk(`ATW_OFS_ASYNC, 8'h00);
      chk(released, 0);
      test_done;
   end
endmodule // test_async_timer_waveform_unit
